// [common/srsc_pkg.sv]
package srsc_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [15:0] SRSC_ADDR_SYNC_SEL   = 16'hF802;
    localparam logic [15:0] SRSC_ADDR_SCLK_CTRL  = 16'hF803;
    localparam logic [15:0] SRSC_ADDR_IRQ_WIDTH  = 16'hF801;
    localparam logic [15:0] SRSC_ADDR_STATUS     = 16'hF8F0;

    localparam int SRSC_NUM_CH     = 4;
    localparam int SRSC_CH_FIELD_W = 8;

    // bit positions inside one 8-bit channel field (channel 0 at 31:24)
    localparam int SRSC_F_IRQ      = 7;
    localparam int SRSC_F_IN_HOLD  = 6;
    localparam int SRSC_F_CARRIER  = 5;
    localparam int SRSC_F_FIR      = 4;
    localparam int SRSC_F_AGC      = 3;
    localparam int SRSC_F_TIMING   = 2;
    localparam int SRSC_F_CIC      = 1;
    localparam int SRSC_F_SER      = 0;

    // serial clock control fields
    localparam int SRSC_SC_HOLD    = 5;
    localparam int SRSC_SC_DIVRST  = 4;
    localparam int SRSC_SC_POL     = 3;
    localparam int SRSC_SC_RATE_HI = 2;
    localparam int SRSC_SC_RATE_LO = 0;

    // interrupt width field of the routing word
    localparam int SRSC_IW_HI      = 23;
    localparam int SRSC_IW_LO      = 20;

    localparam logic [31:0] SRSC_SYNC_SEL_RST  = 32'h0000_0000;
    localparam logic [15:0] SRSC_SCLK_CTRL_RST = 16'h0000;
    localparam logic [3:0]  SRSC_IRQ_WIDTH_RST = 4'h1;

    localparam logic [2:0] SRSC_RATE_OFF  = 3'h0;
    localparam logic [2:0] SRSC_RATE_DIV1 = 3'h1;
    localparam logic [2:0] SRSC_RATE_DIV2 = 3'h2;
    localparam logic [2:0] SRSC_RATE_DIV4 = 3'h3;
    localparam logic [2:0] SRSC_RATE_DIV8 = 3'h4;
    localparam logic [2:0] SRSC_RATE_DIV16 = 3'h5;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int SRSC_CLK_MHZ       = 25;
    localparam int SRSC_FIR_INIT_CLKS = 32;
    localparam logic [5:0] SRSC_FIR_INIT_CNT = 6'(SRSC_FIR_INIT_CLKS);

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } srsc_bus_req_s;

    // per-channel strobes toward the datapath
    typedef struct packed {
        logic carrier_load;
        logic timing_load;
        logic fir_reset;
        logic agc_reset;
        logic cic_reset;
        logic ser_reset;
    } srsc_ch_act_s;

    typedef enum logic [1:0] {
        SRSC_IN_RUN  = 2'b00,
        SRSC_IN_HELD = 2'b01
    } srsc_in_state_e;

endpackage

// [src/srsc_sync_filter.sv]
`timescale 1ns/1ps
module srsc_sync_filter (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    input  wire logic pin_in,
    output logic      rise_pulse
);
    import srsc_pkg::*;

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else if (clk_en) begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // accepted level follows only when stages two and three agree
    always_ff @(posedge core_clk) begin
        if (reset) begin
            level_reg  <= 1'b0;
            rise_pulse <= 1'b0;
        end else if (clk_en) begin
            rise_pulse <= 1'b0;
            if (s2_reg == s3_reg) begin
                level_reg  <= s3_reg;
                rise_pulse <= s3_reg & ~level_reg;
            end
        end
    end
endmodule

// [src/srsc_sclk_gen.sv]
`timescale 1ns/1ps
module srsc_sclk_gen (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic       run,
    input  wire logic [2:0] rate,
    input  wire logic       polarity,
    input  wire logic       div_clear,
    output logic            sclk_out,
    output logic            bit_tick
);
    import srsc_pkg::*;

    logic [3:0] div_reg;
    logic [3:0] div_next;
    logic [3:0] half;
    logic       phase_reg;
    logic       enabled;

    // decode of rate code to half-period mask; div1 toggles at the clock itself
    function automatic logic [3:0] rate_half(input logic [2:0] r);
        case (r)
            SRSC_RATE_DIV2:  rate_half = 4'h0;
            SRSC_RATE_DIV4:  rate_half = 4'h1;
            SRSC_RATE_DIV8:  rate_half = 4'h3;
            SRSC_RATE_DIV16: rate_half = 4'h7;
            default:         rate_half = 4'h0;
        endcase
    endfunction

    assign half     = rate_half(rate);
    assign enabled  = run && (rate != SRSC_RATE_OFF) && (rate <= SRSC_RATE_DIV16);
    assign div_next = (div_reg >= half) ? 4'h0 : div_reg + 4'h1;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            div_reg   <= 4'h0;
            phase_reg <= 1'b0;
            bit_tick  <= 1'b0;
        end else if (clk_en) begin
            bit_tick <= 1'b0;
            if (div_clear || !enabled) begin
                div_reg   <= 4'h0;
                phase_reg <= 1'b0;
            end else if (rate == SRSC_RATE_DIV1) begin
                // full-rate: data changes every clock, so bit_tick is set on every clock rather than taken from the phase flag
                phase_reg <= ~phase_reg;
                bit_tick  <= 1'b1;
            end else begin
                div_reg <= div_next;
                if (div_reg >= half) begin
                    phase_reg <= ~phase_reg;
                    bit_tick  <= phase_reg;
                end
            end
        end
    end

    // second half of each bit is the centre edge; polarity picks its direction
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sclk_out <= 1'b0;
        end else if (clk_en) begin
            if (!enabled || div_clear) begin
                sclk_out <= ~polarity;
            end else begin
                sclk_out <= phase_reg ^ ~polarity;
            end
        end
    end
endmodule

// [src/srsc_top.sv]
`timescale 1ns/1ps
module srsc_top (
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    input  wire logic                  reset_pin,
    input  wire logic                  sw_reset,
    input  wire logic                  sync_in_pulse,
    input  wire logic [3:0]            ch_out_word,
    input  wire logic [3:0]            ch_phase_clear,
    input  wire srsc_pkg::srsc_bus_req_s bus_req,
    output logic [31:0]                bus_rdata,
    output logic [3:0]                 in_enable,
    output logic                       input_mode_gated,
    output srsc_pkg::srsc_ch_act_s [3:0] ch_act,
    output logic [3:0]                 ch_phase_align,
    output logic [3:0]                 fir_busy,
    output logic                       irq_out,
    output logic                       sclk_pin,
    output logic                       sclk_bit_tick
);
    import srsc_pkg::*;

    // ************************************************************
    // registers
    // ************************************************************
    logic [31:0] sync_sel_reg;
    logic [15:0] sclk_ctrl_reg;
    logic [3:0]  irq_width_reg;
    logic        sync_ev;
    logic        hard_rst;
    logic        any_ser_rst;
    logic        sync_seen_reg;
    logic        sclk_run;
    logic        sclk_raw;
    logic        tick_raw;

    assign hard_rst = reset | reset_pin;

    function automatic logic ch_bit(input logic [31:0] sel, input int ch, input int f);
        ch_bit = sel[(SRSC_NUM_CH - 1 - ch) * SRSC_CH_FIELD_W + f];
    endfunction

    always_ff @(posedge core_clk) begin
        if (hard_rst) begin
            sync_sel_reg  <= SRSC_SYNC_SEL_RST;
            sclk_ctrl_reg <= SRSC_SCLK_CTRL_RST;
            irq_width_reg <= SRSC_IRQ_WIDTH_RST;
        end else if (clk_en && bus_req.wr) begin
            case (bus_req.addr)
                SRSC_ADDR_SYNC_SEL:  sync_sel_reg  <= bus_req.wdata;
                SRSC_ADDR_SCLK_CTRL: sclk_ctrl_reg <= bus_req.wdata[15:0];
                SRSC_ADDR_IRQ_WIDTH: irq_width_reg <= bus_req.wdata[SRSC_IW_HI:SRSC_IW_LO];
                default: ;
            endcase
        end
    end

    logic [3:0] irq_cnt_reg;

    always_ff @(posedge core_clk) begin
        if (hard_rst) begin
            bus_rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            bus_rdata <= 32'h0000_0000;
            if (bus_req.rd) begin
                case (bus_req.addr)
                    SRSC_ADDR_SYNC_SEL:  bus_rdata <= sync_sel_reg;
                    SRSC_ADDR_SCLK_CTRL: bus_rdata <= {16'h0000, sclk_ctrl_reg};
                    SRSC_ADDR_IRQ_WIDTH: bus_rdata <= {8'h00, irq_width_reg, 20'h00000};
                    SRSC_ADDR_STATUS:    bus_rdata <= {19'h00000, sclk_run, irq_cnt_reg,
                                                       fir_busy, in_enable};
                    default:             bus_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************
    // sync detection
    // ************************************************************
    srsc_sync_filter u_sync (
        .core_clk   (core_clk),
        .reset      (hard_rst),
        .clk_en     (clk_en),
        .pin_in     (sync_in_pulse),
        .rise_pulse (sync_ev)
    );

    // ************************************************************
    // per-channel input gating and sync actions
    // ************************************************************
    srsc_in_state_e in_state_reg [SRSC_NUM_CH];
    logic [5:0]     fir_cnt_reg  [SRSC_NUM_CH];
    logic [3:0]     ser_rst_vec;

    genvar gi;
    generate
        for (gi = 0; gi < SRSC_NUM_CH; gi++) begin : g_ch
            always_ff @(posedge core_clk) begin
                if (hard_rst) begin
                    in_state_reg[gi] <= SRSC_IN_HELD;
                    in_enable[gi]    <= 1'b0;
                end else if (clk_en) begin
                    case (in_state_reg[gi])
                        SRSC_IN_RUN: begin
                            if (sw_reset && ch_bit(sync_sel_reg, gi, SRSC_F_IN_HOLD)) begin
                                in_state_reg[gi] <= SRSC_IN_HELD;
                                in_enable[gi]    <= 1'b0;
                            end else begin
                                in_enable[gi] <= 1'b1;
                            end
                        end
                        SRSC_IN_HELD: begin
                            // sync sample itself is the first enabled one
                            if (sync_ev) begin
                                in_state_reg[gi] <= SRSC_IN_RUN;
                                in_enable[gi]    <= 1'b1;
                            end else begin
                                in_enable[gi] <= 1'b0;
                            end
                        end
                        default: begin
                            in_state_reg[gi] <= SRSC_IN_HELD;
                            in_enable[gi]    <= 1'b0;
                        end
                    endcase
                end
            end

            always_ff @(posedge core_clk) begin
                if (hard_rst) begin
                    ch_act[gi]         <= '0;
                    ch_phase_align[gi] <= 1'b0;
                end else if (clk_en) begin
                    ch_act[gi].carrier_load <= sync_ev
                        && ch_bit(sync_sel_reg, gi, SRSC_F_CARRIER);
                    ch_act[gi].timing_load  <= sync_ev
                        && ch_bit(sync_sel_reg, gi, SRSC_F_TIMING);
                    ch_act[gi].fir_reset    <= sync_ev
                        && ch_bit(sync_sel_reg, gi, SRSC_F_FIR);
                    ch_act[gi].agc_reset    <= sync_ev
                        && ch_bit(sync_sel_reg, gi, SRSC_F_AGC);
                    ch_act[gi].cic_reset    <= sync_ev
                        && ch_bit(sync_sel_reg, gi, SRSC_F_CIC);
                    ch_act[gi].ser_reset    <= ser_rst_vec[gi];
                    // phase clear on load makes the synced load phase-aligning
                    ch_phase_align[gi] <= sync_ev && ch_phase_clear[gi]
                        && (ch_bit(sync_sel_reg, gi, SRSC_F_CARRIER)
                            || ch_bit(sync_sel_reg, gi, SRSC_F_TIMING));
                end
            end

            always_ff @(posedge core_clk) begin
                if (hard_rst) begin
                    fir_cnt_reg[gi] <= 6'h00;
                    fir_busy[gi]    <= 1'b0;
                end else if (clk_en) begin
                    if (sync_ev && ch_bit(sync_sel_reg, gi, SRSC_F_FIR)) begin
                        fir_cnt_reg[gi] <= SRSC_FIR_INIT_CNT;
                        fir_busy[gi]    <= 1'b1;
                    end else if (fir_cnt_reg[gi] != 6'h00) begin
                        fir_cnt_reg[gi] <= fir_cnt_reg[gi] - 6'h01;
                        fir_busy[gi]    <= (fir_cnt_reg[gi] != 6'h01);
                    end else begin
                        fir_busy[gi] <= 1'b0;
                    end
                end
            end

            assign ser_rst_vec[gi] = sync_ev && ch_bit(sync_sel_reg, gi, SRSC_F_SER);
        end
    endgenerate

    // input mode forced to gated by the reset pin; software may not change it here
    always_ff @(posedge core_clk) begin
        if (hard_rst) begin
            input_mode_gated <= 1'b1;
        end else if (clk_en) begin
            input_mode_gated <= input_mode_gated;
        end
    end

    // ************************************************************
    // output-word interrupt
    // ************************************************************
    logic irq_trig;
    always_comb begin
        irq_trig = 1'b0;
        for (int c = 0; c < SRSC_NUM_CH; c++) begin
            if (ch_out_word[c] && ch_bit(sync_sel_reg, c, SRSC_F_IRQ)) begin
                irq_trig = 1'b1;
            end
        end
    end

    // counter clears only on hard reset so a running pulse always completes
    always_ff @(posedge core_clk) begin
        if (hard_rst) begin
            irq_cnt_reg <= 4'h0;
            irq_out     <= 1'b0;
        end else if (clk_en) begin
            if (irq_trig && irq_cnt_reg == 4'h0 && irq_width_reg != 4'h0) begin
                irq_cnt_reg <= irq_width_reg;
                irq_out     <= 1'b1;
            end else if (irq_cnt_reg != 4'h0) begin
                irq_cnt_reg <= irq_cnt_reg - 4'h1;
                irq_out     <= (irq_cnt_reg != 4'h1);
            end else begin
                irq_out <= 1'b0;
            end
        end
    end

    // ************************************************************
    // serial clock
    // ************************************************************
    assign any_ser_rst = |ser_rst_vec;

    // remembers a sync since hard reset, so the hold bit still stops the clock
    // when it is written after reset but before the first sync
    always_ff @(posedge core_clk) begin
        if (hard_rst) begin
            sync_seen_reg <= 1'b0;
        end else if (clk_en && sync_ev) begin
            sync_seen_reg <= 1'b1;
        end
    end

    assign sclk_run = !sclk_ctrl_reg[SRSC_SC_HOLD] || sync_seen_reg;

    srsc_sclk_gen u_sclk (
        .core_clk  (core_clk),
        .reset     (hard_rst),
        .clk_en    (clk_en),
        .run       (sclk_run),
        .rate      (sclk_ctrl_reg[SRSC_SC_RATE_HI:SRSC_SC_RATE_LO]),
        .polarity  (sclk_ctrl_reg[SRSC_SC_POL]),
        .div_clear (any_ser_rst && sclk_ctrl_reg[SRSC_SC_DIVRST]),
        .sclk_out  (sclk_raw),
        .bit_tick  (tick_raw)
    );

    always_ff @(posedge core_clk) begin
        if (hard_rst) begin
            sclk_pin      <= 1'b0;
            sclk_bit_tick <= 1'b0;
        end else if (clk_en) begin
            sclk_pin      <= sclk_raw;
            sclk_bit_tick <= tick_raw;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_fir_start(int c);
        clk_en && sync_ev && ch_bit(sync_sel_reg, c, SRSC_F_FIR);
    endsequence

    a_irq_pulse_start: assert property (@(posedge core_clk) disable iff (hard_rst)
        clk_en && irq_trig && irq_cnt_reg == 4'h0 && irq_width_reg != 4'h0 |=> irq_out)
        else $error("interrupt pulse did not start");
    a_irq_pulse_end: assert property (@(posedge core_clk) disable iff (hard_rst)
        clk_en && irq_cnt_reg == 4'h1 |=> !irq_out)
        else $error("interrupt pulse overran");
    a_fir_busy_len: assert property (@(posedge core_clk) disable iff (hard_rst)
        s_fir_start(0) |=> fir_busy[0] && fir_cnt_reg[0] == SRSC_FIR_INIT_CNT)
        else $error("fir init count wrong");
    a_in_release_sync: assert property (@(posedge core_clk) disable iff (hard_rst)
        clk_en && in_state_reg[0] == SRSC_IN_HELD && sync_ev |=> in_enable[0])
        else $error("input enable not released on sync");
    a_in_hold_swrst: assert property (@(posedge core_clk) disable iff (hard_rst)
        clk_en && !sync_ev && sw_reset && ch_bit(sync_sel_reg, 3, SRSC_F_IN_HOLD)
        |=> !in_enable[3])
        else $error("input enable not held on software reset");
    a_carrier_load: assert property (@(posedge core_clk) disable iff (hard_rst)
        clk_en && sync_ev && ch_bit(sync_sel_reg, 0, SRSC_F_CARRIER) |=> ch_act[0].carrier_load)
        else $error("carrier load missing");
    a_cic_reset: assert property (@(posedge core_clk) disable iff (hard_rst)
        clk_en && !ch_act[2].cic_reset |-> !$past(sync_ev) || !$past(clk_en)
        || !ch_bit($past(sync_sel_reg), 2, SRSC_F_CIC))
        else $error("cic reset missing");
    a_sclk_hold: assert property (@(posedge core_clk) disable iff (hard_rst)
        !sclk_run |-> ##1 (sclk_run || $stable(sclk_raw)))
        else $error("serial clock ran while held");
    a_gated_mode: assert property (@(posedge core_clk)
        reset_pin |=> input_mode_gated)
        else $error("input mode not gated");
endmodule

// [verif/srsc_sync_src.sv]
`timescale 1ns/1ps
// ************************************************************
// external sync pulse source
// ************************************************************
module srsc_sync_src (
    input  wire logic core_clk,
    input  wire logic fire,
    output logic      sync_in_pulse
);
    logic [2:0] hold_reg = 3'h0;

    // pin stays high 5 cycles, above the filter's 2-cycle minimum
    always_ff @(posedge core_clk) begin
        if (fire) begin
            hold_reg <= 3'h5;
        end else if (hold_reg != 3'h0) begin
            hold_reg <= hold_reg - 3'h1;
        end
    end

    assign sync_in_pulse = (hold_reg != 3'h0);
endmodule

// [verif/srsc_top_tb.sv]
`timescale 1ns/1ps
module srsc_top_tb;
    import srsc_pkg::*;
    localparam logic [31:0] SEL = 32'h300C_0340;
    logic               core_clk;
    logic               reset;
    logic               reset_pin;
    logic               clk_en;
    logic               sw_reset;
    logic               fire;
    logic               sync_in_pulse;
    logic [3:0]         ch_out_word;
    logic [3:0]         ch_phase_clear;
    logic [3:0]         in_enable;
    logic [3:0]         ch_phase_align;
    logic [3:0]         fir_busy;
    logic [3:0]         align_seen;
    srsc_bus_req_s      bus_req;
    logic [31:0]        bus_rdata;
    logic [31:0]        rdv;
    logic               input_mode_gated;
    logic               irq_out;
    logic               sclk_pin;
    logic               sclk_bit_tick;
    srsc_ch_act_s [3:0] ch_act;
    logic [23:0]        act_seen;
    logic [23:0]        act_exp;
    int                 errors;
    int                 check_count;
    int                 n;
    int                 busy;
    int                 m;

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    srsc_top i_dut (
        .core_clk         (core_clk),
        .reset            (reset),
        .clk_en           (clk_en),
        .reset_pin        (reset_pin),
        .sw_reset         (sw_reset),
        .sync_in_pulse    (sync_in_pulse),
        .ch_out_word      (ch_out_word),
        .ch_phase_clear   (ch_phase_clear),
        .bus_req          (bus_req),
        .bus_rdata        (bus_rdata),
        .in_enable        (in_enable),
        .input_mode_gated (input_mode_gated),
        .ch_act           (ch_act),
        .ch_phase_align   (ch_phase_align),
        .fir_busy         (fir_busy),
        .irq_out          (irq_out),
        .sclk_pin         (sclk_pin),
        .sclk_bit_tick    (sclk_bit_tick)
    );

    srsc_sync_src i_sync (
        .core_clk      (core_clk),
        .fire          (fire),
        .sync_in_pulse (sync_in_pulse)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [5:0] exp_act(input logic [7:0] f);
        return {f[SRSC_F_CARRIER], f[SRSC_F_TIMING], f[SRSC_F_FIR],
                f[SRSC_F_AGC], f[SRSC_F_CIC], f[SRSC_F_SER]};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        bus_req <= '{a, 32'h0, 1'b0, 1'b0};
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge core_clk);
        bus_req <= '{a, 32'h0, 1'b0, 1'b0};
        #1;
        d = bus_rdata;
    endtask

    // which: 0 counts serial bit ticks, 1 counts interrupt cycles
    task automatic count_hi(input int cyc, input int which, output int c);
        c = 0;
        repeat (cyc) begin
            @(posedge core_clk);
            #1;
            c += (which == 0) ? int'(sclk_bit_tick === 1'b1) : int'(irq_out === 1'b1);
        end
    endtask

    task automatic do_sync();
        @(posedge core_clk);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        act_seen = '0;
        align_seen = '0;
        busy = 0;
        repeat (45) begin
            @(posedge core_clk);
            #1;
            act_seen |= ch_act;
            align_seen |= ch_phase_align;
            busy += int'(fir_busy[0] === 1'b1);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        tally_and_finish();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        errors = 0;
        check_count = 0;
        reset = 1'b1;
        reset_pin = 1'b0;
        clk_en = 1'b1;
        sw_reset = 1'b0;
        fire = 1'b0;
        ch_out_word = 4'h0;
        ch_phase_clear = 4'h1;
        bus_req = '0;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        rd(SRSC_ADDR_SYNC_SEL, rdv);
        chk("sync select reset", 32'h0, rdv);
        rd(SRSC_ADDR_SCLK_CTRL, rdv);
        chk("serial control reset", 32'h0, rdv);
        rd(SRSC_ADDR_IRQ_WIDTH, rdv);
        chk("irq width reset", 32'h0010_0000, rdv);
        rd(16'hF8AA, rdv);
        chk("unmapped read", 32'h0, rdv);
        chk("enable after reset", 32'h0, in_enable);
        chk("gated after reset", 32'h1, input_mode_gated);
        $display("test reset values done");

        wr(SRSC_ADDR_SYNC_SEL, SEL);
        wr(16'hF8AA, 32'hFFFF_FFFF);
        wr(SRSC_ADDR_SCLK_CTRL, 32'h0000_0012);
        rd(SRSC_ADDR_SYNC_SEL, rdv);
        chk("sync select readback", SEL, rdv);
        do_sync();
        for (int c = 0; c < 4; c++) begin
            act_exp[6*c +: 6] = exp_act(SEL[31-8*c -: 8]);
        end
        chk("channel actions", act_exp, act_seen);
        chk("phase align", 32'h1, align_seen);
        chk("fir busy cycles", SRSC_FIR_INIT_CLKS, busy);
        chk("enable after sync", 32'hF, in_enable);
        $display("test sync actions done");

        @(posedge core_clk);
        sw_reset <= 1'b1;
        @(posedge core_clk);
        sw_reset <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk("enable after sw reset", 32'h7, in_enable);
        do_sync();
        chk("enable after resync", 32'hF, in_enable);
        @(posedge core_clk);
        reset_pin <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset_pin <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("enable after pin", 32'h0, in_enable);
        chk("gated after pin", 32'h1, input_mode_gated);
        $display("test input hold done");

        wr(SRSC_ADDR_SCLK_CTRL, 32'h0000_0022);
        count_hi(64, 0, n);
        chk("ticks while held", 32'h0, n);
        do_sync();
        count_hi(64, 0, n);
        chk("ticks after sync", 32'd32, n);
        for (int r = 1; r <= 5; r++) begin
            wr(SRSC_ADDR_SCLK_CTRL, 32'(r));
            repeat (4) @(posedge core_clk);
            count_hi(128, 0, n);
            chk("ticks per rate", 32'(128 >> (r - 1)), n);
        end
        for (int p = 0; p < 2; p++) begin
            wr(SRSC_ADDR_SCLK_CTRL, 32'(p << SRSC_SC_POL));
            count_hi(32, 0, n);
            chk("ticks when off", 32'h0, n);
            chk("idle level", 32'(p == 0), sclk_pin);
        end
        $display("test serial clock done");

        // a write while the clock enable is low must be lost
        clk_en <= 1'b0;
        wr(SRSC_ADDR_SYNC_SEL, 32'hFFFF_FFFF);
        clk_en <= 1'b1;
        rd(SRSC_ADDR_SYNC_SEL, rdv);
        chk("write while frozen", 32'h0, rdv);
        $display("test clock enable done");

        wr(SRSC_ADDR_SYNC_SEL, 32'h8000_0000);
        for (int k = 0; k < 4; k++) begin
            n = (k == 0) ? 1 : (k == 1) ? 3 : 15;
            wr(SRSC_ADDR_IRQ_WIDTH, 32'(n) << SRSC_IW_LO);
            ch_out_word <= (k == 3) ? 4'h2 : 4'h1;
            @(posedge core_clk);
            ch_out_word <= 4'h0;
            #1;
            busy = int'(irq_out === 1'b1);
            count_hi(23, 1, m);
            chk("irq cycles", (k == 3) ? 32'h0 : 32'(n), 32'(busy + m));
        end
        $display("test interrupt done");
        tally_and_finish();
    end
endmodule
